/* File: rre_exec_unit.sv */
// Return and rotate execution unit
// Functional notes
// - Plain return loads the program counter from the popped stack entry.
// - Return with immediate restores PC and writes immediate to accumulator.
// - Interrupt return restores PC and sets master interrupt enable to one.
// - Pending interrupt at interrupt return is serviced before main program resumes.
// - Rotate left in place writes rotated byte back, bit 7 into bit 0.
// - Rotate left to accumulator places rotated byte in accumulator only.
// - Rotate left through carry writes memory; old bit 7 becomes carry.
// - Rotate left carry to accumulator writes accumulator; carry from old bit 7.
// - Rotate right in place writes rotated byte back, bit 0 into bit 7.
// - Rotate right to accumulator places rotated byte in accumulator only.
// - Rotate right through carry writes memory; old bit 0 becomes carry.
// - Rotate right carry to accumulator writes accumulator; carry from old bit 0.
`timescale 1ns/1ps
`include "rre_defs.svh"
module rre_exec_unit #(
  parameter int DEPTH = `RRE_STACK_DEPTH,
  parameter int SP_W = `RRE_SP_W,
  parameter int PC_W = `RRE_PC_W
) (
  input wire logic i_clk, // Core clock
  input wire logic i_resetn, // Async reset, active low
  input wire rre_pkg::rre_cmd_s i_cmd, // Instruction and immediate
  input wire logic [7:0] i_mem_rdata, // Addressed data memory byte
  input wire logic i_push, // Call or interrupt entry pushes a return address
  input wire logic [PC_W-1:0] i_push_pc, // Address pushed
  input wire logic i_irq_pending, // An interrupt request is waiting
  input wire logic i_mie_clear, // Interrupt entry clears the master enable
  output logic [PC_W-1:0] o_pc, // Program counter load value
  output logic o_pc_load, // Program counter load strobe
  output logic [7:0] o_acc, // Accumulator
  output logic o_carry, // Carry flag
  output logic o_master_interrupt_enable, // Master interrupt enable
  output rre_pkg::rre_mem_wr_s o_mem_wr, // Data memory write back
  output logic o_irq_take, // Pending interrupt taken after interrupt return
  output logic [SP_W-1:0] o_sp // Stack pointer
);
  import rre_pkg::*;

  logic [PC_W-1:0] stack [DEPTH];
  logic [SP_W-1:0] sp;
  logic [SP_W-1:0] next_sp;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] next_pc;
  logic pc_load;
  logic next_pc_load;
  logic [7:0] acc;
  logic [7:0] next_acc;
  logic carry;
  logic next_carry;
  logic mie;
  logic next_mie;
  rre_mem_wr_s mem_wr;
  rre_mem_wr_s next_mem_wr;
  logic irq_take;
  logic next_irq_take;
  logic is_ret;
  logic rot_right;
  logic rot_thru;
  logic [7:0] rot_data;
  logic rot_carry;
  logic [SP_W-1:0] top;

  // Shared rotator for all eight rotate forms
  rre_rotator #(.W(8)) u_rot (
    .i_data(i_mem_rdata),
    .i_carry(carry),
    .i_right(rot_right),
    .i_thru_carry(rot_thru),
    .o_data(rot_data),
    .o_carry(rot_carry)
  );

  // Decode rotate direction and carry use
  always_comb begin
    rot_right = i_cmd.op inside {RRE_OP_ROTATE_RIGHT_IN_PLACE, RRE_OP_ROTATE_RIGHT_TO_ACC,
      RRE_OP_ROTATE_RIGHT_THROUGH_CARRY, RRE_OP_ROTATE_RIGHT_CARRY_TO_ACC};
    rot_thru = i_cmd.op inside {RRE_OP_ROTATE_LEFT_THROUGH_CARRY,
      RRE_OP_ROTATE_LEFT_CARRY_TO_ACC, RRE_OP_ROTATE_RIGHT_THROUGH_CARRY,
      RRE_OP_ROTATE_RIGHT_CARRY_TO_ACC};
    is_ret = i_cmd.valid && (i_cmd.op inside {RRE_OP_RETURN, RRE_OP_RETURN_WITH_IMMEDIATE,
      RRE_OP_RETURN_FROM_INTERRUPT});
    top = sp - SP_W'(1);
  end

  // Next state of execution results
  always_comb begin
    next_sp = sp;
    next_pc = pc;
    next_pc_load = 1'b0;
    next_acc = acc;
    next_carry = carry;
    next_mie = mie;
    next_mem_wr = '{we: 1'b0, data: mem_wr.data};
    next_irq_take = 1'b0;
    if (i_mie_clear) begin
      next_mie = 1'b0;
    end
    if (i_push) begin
      next_sp = sp + SP_W'(1);
    end
    if (i_cmd.valid) begin
      unique case (i_cmd.op)
        RRE_OP_NONE: begin
        end
        RRE_OP_RETURN: begin
          next_pc = stack[top];
          next_pc_load = 1'b1;
        end
        RRE_OP_RETURN_WITH_IMMEDIATE: begin
          next_pc = stack[top];
          next_pc_load = 1'b1;
          next_acc = i_cmd.operand;
        end
        RRE_OP_RETURN_FROM_INTERRUPT: begin
          next_pc = stack[top];
          next_pc_load = 1'b1;
          next_mie = 1'b1;
          next_irq_take = i_irq_pending;
        end
        RRE_OP_ROTATE_LEFT_IN_PLACE, RRE_OP_ROTATE_RIGHT_IN_PLACE: begin
          next_mem_wr = '{we: 1'b1, data: rot_data};
        end
        RRE_OP_ROTATE_LEFT_TO_ACC, RRE_OP_ROTATE_RIGHT_TO_ACC: begin
          next_acc = rot_data;
        end
        RRE_OP_ROTATE_LEFT_THROUGH_CARRY, RRE_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
          next_mem_wr = '{we: 1'b1, data: rot_data};
          next_carry = rot_carry;
        end
        RRE_OP_ROTATE_LEFT_CARRY_TO_ACC, RRE_OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
          next_acc = rot_data;
          next_carry = rot_carry;
        end
        default: begin
        end
      endcase
    end
    if (is_ret) begin
      next_sp = i_push ? sp : top;
    end
  end

  // Register execution results
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sp <= '0;
      pc <= '0;
      pc_load <= 1'b0;
      acc <= `RRE_ACC_RST;
      carry <= `RRE_CARRY_RST;
      mie <= `RRE_MIE_RST;
      mem_wr <= '0;
      irq_take <= 1'b0;
    end else begin
      sp <= next_sp;
      pc <= next_pc;
      pc_load <= next_pc_load;
      acc <= next_acc;
      carry <= next_carry;
      mie <= next_mie;
      mem_wr <= next_mem_wr;
      irq_take <= next_irq_take;
    end
  end

  // Stack storage, written on push
  always_ff @(posedge i_clk) begin
    if (i_push) begin
      stack[is_ret ? top : sp] <= i_push_pc;
    end
  end

  assign o_pc = pc;
  assign o_pc_load = pc_load;
  assign o_acc = acc;
  assign o_carry = carry;
  assign o_master_interrupt_enable = mie;
  assign o_mem_wr = mem_wr;
  assign o_irq_take = irq_take;
  assign o_sp = sp;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_ret_pc_load: assert property (is_ret |=> pc_load)
    else $error("return did not load pc");
  a_imm_acc: assert property (
    i_cmd.valid && i_cmd.op == RRE_OP_RETURN_WITH_IMMEDIATE |=> acc == $past(i_cmd.operand))
    else $error("immediate not loaded");
  a_irq_ret_mie: assert property (
    i_cmd.valid && i_cmd.op == RRE_OP_RETURN_FROM_INTERRUPT |=> mie)
    else $error("master enable not set");
  a_irq_ret_take: assert property (
    i_cmd.valid && i_cmd.op == RRE_OP_RETURN_FROM_INTERRUPT && i_irq_pending |=> irq_take)
    else $error("pending interrupt not taken");
  a_rotl_mem: assert property (
    i_cmd.valid && i_cmd.op == RRE_OP_ROTATE_LEFT_IN_PLACE
    |=> mem_wr.we && mem_wr.data == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])}
    && $stable(carry))
    else $error("rotate left in place wrong");
  a_rotl_acc: assert property (
    i_cmd.valid && i_cmd.op == RRE_OP_ROTATE_LEFT_TO_ACC
    |=> !mem_wr.we && acc == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])}
    && $stable(carry))
    else $error("rotate left to acc wrong");
  a_rotlc_mem: assert property (
    i_cmd.valid && i_cmd.op == RRE_OP_ROTATE_LEFT_THROUGH_CARRY
    |=> carry == $past(i_mem_rdata[7]) && mem_wr.data[0] == $past(carry))
    else $error("rotate left through carry wrong");
  a_rotlc_acc: assert property (
    i_cmd.valid && i_cmd.op == RRE_OP_ROTATE_LEFT_CARRY_TO_ACC
    |=> carry == $past(i_mem_rdata[7]) && acc[0] == $past(carry))
    else $error("rotate left carry to acc wrong");
  a_rotr_mem: assert property (
    i_cmd.valid && i_cmd.op == RRE_OP_ROTATE_RIGHT_IN_PLACE
    |=> mem_wr.we && mem_wr.data == {$past(i_mem_rdata[0]), $past(i_mem_rdata[7:1])}
    && $stable(carry))
    else $error("rotate right in place wrong");
  a_rotr_acc: assert property (
    i_cmd.valid && i_cmd.op == RRE_OP_ROTATE_RIGHT_TO_ACC
    |=> !mem_wr.we && acc == {$past(i_mem_rdata[0]), $past(i_mem_rdata[7:1])}
    && $stable(carry))
    else $error("rotate right to acc wrong");
  a_rotrc_mem: assert property (
    i_cmd.valid && i_cmd.op == RRE_OP_ROTATE_RIGHT_THROUGH_CARRY
    |=> carry == $past(i_mem_rdata[0]) && mem_wr.data[7] == $past(carry))
    else $error("rotate right through carry wrong");
  a_rotrc_acc: assert property (
    i_cmd.valid && i_cmd.op == RRE_OP_ROTATE_RIGHT_CARRY_TO_ACC
    |=> carry == $past(i_mem_rdata[0]) && acc[7] == $past(carry))
    else $error("rotate right carry to acc wrong");
  a_ret_pop: assert property (is_ret && !i_push |=> sp == $past(sp) - SP_W'(1))
    else $error("stack not popped once");

  c_irq_ret_pending: cover property (i_cmd.valid && i_cmd.op == RRE_OP_RETURN_FROM_INTERRUPT
    && i_irq_pending);
  c_push_ret: cover property (i_push && is_ret);
  c_rotlc_mem: cover property (i_cmd.valid && i_cmd.op == RRE_OP_ROTATE_LEFT_THROUGH_CARRY);
  c_rotrc_acc: cover property (i_cmd.valid && i_cmd.op == RRE_OP_ROTATE_RIGHT_CARRY_TO_ACC);
endmodule // rre_exec_unit

/* File: rre_defs.svh */
// Constants for the return and rotate execution unit
`ifndef RRE_DEFS_SVH
`define RRE_DEFS_SVH
`define RRE_DATA_W 8
`define RRE_PC_W 13
`define RRE_STACK_DEPTH 8
`define RRE_SP_W 3
`define RRE_ACC_RST 8'h00
`define RRE_CARRY_RST 1'b0
`define RRE_MIE_RST 1'b0
`define RRE_MSB 7
`define RRE_LSB 0
`endif

/* File: rre_pkg.sv */
// Types for the return and rotate execution unit
package rre_pkg;
  typedef enum logic [3:0] {
    RRE_OP_NONE = 4'h0,
    RRE_OP_RETURN = 4'h1,
    RRE_OP_RETURN_WITH_IMMEDIATE = 4'h2,
    RRE_OP_RETURN_FROM_INTERRUPT = 4'h3,
    RRE_OP_ROTATE_LEFT_IN_PLACE = 4'h4,
    RRE_OP_ROTATE_LEFT_TO_ACC = 4'h5,
    RRE_OP_ROTATE_LEFT_THROUGH_CARRY = 4'h6,
    RRE_OP_ROTATE_LEFT_CARRY_TO_ACC = 4'h7,
    RRE_OP_ROTATE_RIGHT_IN_PLACE = 4'h8,
    RRE_OP_ROTATE_RIGHT_TO_ACC = 4'h9,
    RRE_OP_ROTATE_RIGHT_THROUGH_CARRY = 4'ha,
    RRE_OP_ROTATE_RIGHT_CARRY_TO_ACC = 4'hb
  } rre_op_e;

  // Instruction issued by the sequencer
  typedef struct packed {
    logic valid;
    rre_op_e op;
    logic [7:0] operand;
  } rre_cmd_s;

  // Data memory write request
  typedef struct packed {
    logic we;
    logic [7:0] data;
  } rre_mem_wr_s;
endpackage

/* File: rre_rotator.sv */
// Combinational 8-bit rotator, optionally through carry
`timescale 1ns/1ps
`include "rre_defs.svh"
module rre_rotator #(
  parameter int W = 8
) (
  input wire logic [W-1:0] i_data, // Byte to rotate
  input wire logic i_carry, // Current carry flag
  input wire logic i_right, // 1 rotates right
  input wire logic i_thru_carry, // 1 rotates through carry
  output logic [W-1:0] o_data, // Rotated byte
  output logic o_carry // Carry after rotation
);
  // Select the bit entering the vacated end and the bit leaving
  always_comb begin
    if (i_right) begin
      o_data = {(i_thru_carry ? i_carry : i_data[0]), i_data[W-1:1]};
      o_carry = i_thru_carry ? i_data[0] : i_carry;
    end else begin
      o_data = {i_data[W-2:0], (i_thru_carry ? i_carry : i_data[W-1])};
      o_carry = i_thru_carry ? i_data[W-1] : i_carry;
    end
  end
endmodule // rre_rotator

/* File: rre_mem_model.sv */
// Data memory cell model facing the unit's write-back port
`timescale 1ns/1ps
module rre_mem_model
  import rre_pkg::*;
(
  input wire logic i_clk, // Core clock
  input wire logic i_resetn, // Async reset, active low
  input wire rre_pkg::rre_mem_wr_s i_wr, // Write back from the unit
  input wire logic i_load, // Bench preloads the cell
  input wire logic [7:0] i_load_data, // Preload value
  output logic [7:0] o_rdata // Addressed byte
);
  // Cell keeps its byte until written back or preloaded
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_wr.we) begin
      o_rdata <= i_wr.data; // Write back lands one edge after the pulse
    end else if (i_load) begin
      o_rdata <= i_load_data;
    end
  end
endmodule // rre_mem_model

/* File: rre_exec_unit_bench.sv */
// Self-checking bench for the return and rotate execution unit
`timescale 1ns/1ps
module rre_exec_unit_bench;
  import rre_pkg::*;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_push = 1'b0, i_irq_pending = 1'b0;
  logic i_mie_clear = 1'b0, ld = 1'b0, o_pc_load, o_carry, o_mie, o_irq_take;
  logic [12:0] i_push_pc = 13'h0000, o_pc;
  logic [7:0] ld_data = 8'h00, mem_q, o_acc, acc, mem, m, r;
  logic [2:0] o_sp, sp;
  logic c, mie, e_ld, e_we, e_irq;
  logic [12:0] stk [8];
  logic [12:0] e_pc;
  rre_cmd_s i_cmd = '0;
  rre_mem_wr_s o_mem_wr;
  int err_count = 0, tests_run = 0, cycles = 0;
  // Clock at 50 ns and a cycle ceiling against hangs
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
  end
  rre_exec_unit dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_cmd(i_cmd), .i_mem_rdata(mem_q),
    .i_push(i_push), .i_push_pc(i_push_pc), .i_irq_pending(i_irq_pending),
    .i_mie_clear(i_mie_clear), .o_pc(o_pc), .o_pc_load(o_pc_load), .o_acc(o_acc),
    .o_carry(o_carry), .o_master_interrupt_enable(o_mie), .o_mem_wr(o_mem_wr),
    .o_irq_take(o_irq_take), .o_sp(o_sp));
  rre_mem_model mem_cell (.i_clk(i_clk), .i_resetn(i_resetn), .i_wr(o_mem_wr), .i_load(ld),
    .i_load_data(ld_data), .o_rdata(mem_q));
  task chk(input logic [15:0] g, input logic [15:0] e, input string s);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t %s got %h want %h", $time, s, g, e);
    end
  endtask
  task end_sim;
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Reset for six cycles, then check every output except o_pc and the write data is cleared
  task do_reset;
    @(negedge i_clk);
    i_resetn = 1'b0;
    repeat (6) @(negedge i_clk);
    i_resetn = 1'b1;
    {acc, mem, c, mie, sp} = '0;
    chk({o_acc, o_carry, o_mie, o_sp, o_pc_load, o_mem_wr.we, o_irq_take}, 16'h0000, "rst");
  endtask
  // Preload the memory cell with a random byte
  task load;
    @(negedge i_clk);
    ld = 1'b1;
    ld_data = 8'($urandom);
    @(negedge i_clk);
    ld = 1'b0;
    mem = ld_data;
  endtask
  // One cycle of stimulus, model update, checks, then pulse release checks
  task step(input logic [3:0] op, input logic v, input logic psh, input logic clr);
    @(negedge i_clk);
    chk(mem_q, mem, "mem before");
    i_cmd = '{valid: v, op: rre_op_e'(op), operand: 8'($urandom)};
    {i_push, i_mie_clear, i_irq_pending} = {psh, clr, 1'($urandom)};
    i_push_pc = 13'($urandom);
    m = mem;
    {e_ld, e_we, e_irq} = 3'h0;
    case (v ? op : 4'h0)
      4'h1, 4'h2, 4'h3: begin
        e_ld = 1'b1;
        sp = sp - 3'h1;
        e_pc = stk[sp];
        if (op == 4'h2) acc = i_cmd.operand;
        e_irq = (op == 4'h3) && i_irq_pending;
      end
      4'h4, 4'h5: r = {m[6:0], m[7]};
      4'h6, 4'h7: {c, r} = {m, c};
      4'h8, 4'h9: r = {m[0], m[7:1]};
      4'ha, 4'hb: {r, c} = {c, m};
      default: r = m;
    endcase
    if (v && op >= 4'h4 && op <= 4'hb) begin
      if (op[0]) acc = r;
      else {e_we, mem} = {1'b1, r};
    end
    if (psh) stk[sp] = i_push_pc;
    if (psh) sp = sp + 3'h1;
    if (clr) mie = 1'b0;
    if (v && op == 4'h3) mie = 1'b1;
    @(negedge i_clk);
    chk(o_acc, acc, "acc");
    chk(o_carry, c, "carry");
    chk(o_mie, mie, "mie");
    chk(o_pc_load, e_ld, "pc load");
    if (e_ld) chk(o_pc, e_pc, "pc");
    chk(o_mem_wr.we, e_we, "we");
    if (e_we) chk(o_mem_wr.data, mem, "wdata");
    chk(o_irq_take, e_irq, "irq take");
    chk(o_sp, sp, "sp");
    i_cmd.valid = 1'b0;
    {i_push, i_mie_clear} = 2'h0;
    @(negedge i_clk);
    chk({o_pc_load, o_mem_wr.we, o_irq_take}, 16'h0000, "pulse");
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hc7c4));
    do_reset();
    $display("Test reset done");
    repeat (8) step(4'h0, 1'b0, 1'b1, 1'b0);
    for (int k = 0; k < 16; k++) begin
      load();
      step(4'(k), 1'b1, 1'b0, 1'b0);
    end
    step(4'h3, 1'b1, 1'b1, 1'b1);
    $display("Test all codes done");
    repeat (120) begin
      if ($urandom % 4 == 0) load();
      step(4'($urandom), 1'($urandom), ($urandom % 3) == 0, ($urandom % 4) == 0);
    end
    $display("Test random mix done");
    do_reset();
    step(4'h2, 1'b1, 1'b0, 1'b0);
    $display("Test second reset done");
    end_sim();
  end
endmodule // rre_exec_unit_bench
